// >>> phy_pkg.sv
// Function
// - Control bit 15 starts self-clearing soft reset; poll it
// - Soft reset restores latched pin defaults, no resample
// - No register access 1 ms after hardware reset
// - Speed bits 6:13, 00=10M, 01=100M, others refused
// - Auto-negotiation enable, speed, duplex default from pins
// - Control bit 14 enables loopback, resets zero
// - Isolate floats MAC outputs, ignores transmit inputs
// - Control bit 9 restarts negotiation, reads zero
// - Control bit 7 enables collision test, resets zero
// - Low control bits written zero, reset zero
// - Status capability bits are fixed constants
// - Preamble suppression unsupported; always send preamble
// - Status bit 5 shows negotiation complete
// - Fault, jabber latch high; link latches low; read clears
// - Second port answers at first port address plus one
`default_nettype none
package phy_pkg;
  localparam int          PORTS           = 2;
  localparam logic [4:0]  REG_CTRL        = 5'h00;
  localparam logic [4:0]  REG_STAT        = 5'h01;
  localparam int          CTL_RESET       = 15;
  localparam int          CTL_LOOP        = 14;
  localparam int          CTL_SPD_LSB     = 13;
  localparam int          CTL_AN_EN       = 12;
  localparam int          CTL_PDOWN       = 11;
  localparam int          CTL_ISOLATE     = 10;
  localparam int          CTL_AN_RESTART  = 9;
  localparam int          CTL_DUPLEX      = 8;
  localparam int          CTL_COL_TEST    = 7;
  localparam int          CTL_SPD_MSB     = 6;
  localparam logic [15:0] CTL_RESET_VAL   = 16'h0000;
  localparam logic [15:0] CTL_STORE_MASK  = 16'h7d80;
  localparam logic [15:0] STAT_FIXED      = 16'h7809;
  localparam int          STAT_AN_DONE    = 5;
  localparam int          STAT_RFAULT     = 4;
  localparam int          STAT_LINK       = 2;
  localparam int          STAT_JABBER     = 1;
  localparam logic [15:0] NO_PHY_DATA     = 16'hffff;
  localparam int          CLK_MHZ         = 125;
  localparam int          REG_WAIT_US     = 1000;
  localparam int          REG_WAIT_CYCLES = REG_WAIT_US * CLK_MHZ;
  localparam int          SW_RESET_CYCLES = 16;
  localparam int          PREAMBLE_BITS   = 32;
  localparam logic [3:0]  HR_CMD          = 4'h0;
  localparam logic [3:0]  HR_RESULT       = 4'h4;
  localparam logic [3:0]  HR_IRQ_STAT     = 4'h8;
  localparam logic [3:0]  HR_IRQ_MASK     = 4'hc;
  localparam int          CMD_REG_LSB     = 16;
  localparam int          CMD_PHY_LSB     = 21;
  localparam int          CMD_WRITE       = 26;
  localparam int          CMD_SWRST       = 27;
  localparam int          RES_BUSY        = 16;
  localparam int          RES_READY       = 17;
  localparam int          IRQ_W           = 2;
  localparam int          IRQ_DONE        = 0;
  localparam int          IRQ_RST_DONE    = 1;
endpackage : phy_pkg
`default_nettype wire

// >>> phy_mgmt_if.sv
`default_nettype none
interface phy_mgmt_if;
  logic        req;
  logic        write;
  logic [4:0]  phy;
  logic [4:0]  regad;
  logic [15:0] wdata;
  logic        ack;
  logic [15:0] rdata;
  modport device (input req, write, phy, regad, wdata, output ack, rdata);
  modport host   (output req, write, phy, regad, wdata, input ack, rdata);
endinterface : phy_mgmt_if
`default_nettype wire

// >>> phy_dev.sv
// The AHB-Lite register port was decided locally.
`default_nettype none
module phy_dev #(
  parameter int PORTS           = phy_pkg::PORTS,
  parameter int REG_WAIT_CYCLES = phy_pkg::REG_WAIT_CYCLES
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  phy_mgmt_if.device            mgmt,
  input  wire logic [3:0]       addr_strap,
  input  wire logic [PORTS-1:0] strap_an_en,
  input  wire logic [PORTS-1:0] strap_speed,
  input  wire logic [PORTS-1:0] strap_duplex,
  input  wire logic [PORTS-1:0] link_up,
  input  wire logic [PORTS-1:0] remote_fault,
  input  wire logic [PORTS-1:0] jabber,
  input  wire logic [PORTS-1:0] an_done,
  input  wire logic [PORTS-1:0] tx_en_in,
  input  wire logic [PORTS-1:0] tx_er_in,
  output logic      [PORTS-1:0] loopback_en,
  output logic      [PORTS-1:0] speed_100,
  output logic      [PORTS-1:0] full_duplex,
  output logic      [PORTS-1:0] an_enable,
  output logic      [PORTS-1:0] an_restart,
  output logic      [PORTS-1:0] power_down,
  output logic      [PORTS-1:0] col_test,
  output logic      [PORTS-1:0] mii_oe,
  output logic      [PORTS-1:0] tx_en_core,
  output logic      [PORTS-1:0] tx_er_core
);
  if (PORTS < 1 || PORTS > 2) begin : g_bad_ports
    $error("phy_dev: PORTS must be 1 or 2");
  end
  if (REG_WAIT_CYCLES < 1) begin : g_bad_wait
    $error("phy_dev: REG_WAIT_CYCLES must be positive");
  end

  localparam int WCW = $clog2(REG_WAIT_CYCLES + 1);
  localparam int SCW = $clog2(phy_pkg::SW_RESET_CYCLES + 1);
  localparam logic [WCW-1:0] WAIT_LAST = WCW'(REG_WAIT_CYCLES);
  localparam logic [SCW-1:0] SW_LOAD   = SCW'(phy_pkg::SW_RESET_CYCLES);

  function automatic logic [15:0] pin_default(input logic spd, input logic anen,
                                              input logic dup);
    logic [15:0] v;
    v = phy_pkg::CTL_RESET_VAL;
    v[phy_pkg::CTL_SPD_LSB] = spd;
    v[phy_pkg::CTL_AN_EN]   = anen;
    v[phy_pkg::CTL_DUPLEX]  = dup;
    return v;
  endfunction : pin_default

  logic             strap_taken_reg;
  logic [3:0]       addr_base_reg;
  logic [WCW-1:0]   wait_cnt_reg;
  logic             ready_reg;
  logic             ack_reg;
  logic [15:0]      rdata_reg;
  logic [15:0]      ctl_reg     [PORTS];
  logic [15:0]      ctl_next    [PORTS];
  logic [15:0]      def_reg     [PORTS];
  logic [SCW-1:0]   sw_cnt_reg  [PORTS];
  logic [SCW-1:0]   sw_cnt_next [PORTS];
  logic [15:0]      stat_word   [PORTS];
  logic [PORTS-1:0] rf_reg;
  logic [PORTS-1:0] jab_reg;
  logic [PORTS-1:0] link_reg;
  logic [PORTS-1:0] hit;
  logic [PORTS-1:0] wr_ctl;
  logic [PORTS-1:0] rd_stat;
  logic [PORTS-1:0] restart_next;
  logic [15:0]      port_rdata;

  // Requests wait, unanswered, until registers become available
  wire take = mgmt.req & ~ack_reg & ready_reg;

  assign mgmt.ack   = ack_reg;
  assign mgmt.rdata = rdata_reg;

  // Latch the straps once, on the first edge after hardware reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_taken_reg <= 1'b0;
      addr_base_reg   <= 4'h0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      addr_base_reg   <= addr_strap;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_cnt_reg <= '0;
      ready_reg    <= 1'b0;
    end else if (!ready_reg) begin
      wait_cnt_reg <= wait_cnt_reg + WCW'(1);
      ready_reg    <= (wait_cnt_reg == WAIT_LAST - WCW'(1));
    end
  end

  // Unmatched PHY addresses read as a floating line would
  always_comb begin
    port_rdata = phy_pkg::NO_PHY_DATA;
    for (int i = 0; i < PORTS; i++) begin
      if (hit[i]) begin
        port_rdata = (mgmt.regad == phy_pkg::REG_CTRL) ? ctl_reg[i] :
                     (mgmt.regad == phy_pkg::REG_STAT) ? stat_word[i] : 16'h0000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      ack_reg <= take;
      if (take && !mgmt.write) begin
        rdata_reg <= port_rdata;
      end
    end
  end

  for (genvar p = 0; p < PORTS; p++) begin : g_port
    wire sw_busy = (sw_cnt_reg[p] != '0);
    wire [15:0] wd = mgmt.wdata;
    // Address LSB is the port index
    assign hit[p]     = (mgmt.phy == {addr_base_reg, 1'(p)});
    assign wr_ctl[p]  = take & mgmt.write & hit[p] & (mgmt.regad == phy_pkg::REG_CTRL);
    assign rd_stat[p] = take & ~mgmt.write & hit[p] & (mgmt.regad == phy_pkg::REG_STAT);

    always_comb begin
      stat_word[p] = phy_pkg::STAT_FIXED;
      stat_word[p][phy_pkg::STAT_AN_DONE] = an_done[p];
      stat_word[p][phy_pkg::STAT_RFAULT]  = rf_reg[p];
      stat_word[p][phy_pkg::STAT_LINK]    = link_reg[p];
      stat_word[p][phy_pkg::STAT_JABBER]  = jab_reg[p];
    end

    always_comb begin
      ctl_next[p]     = ctl_reg[p];
      sw_cnt_next[p]  = sw_cnt_reg[p];
      restart_next[p] = 1'b0;
      if (!strap_taken_reg) begin
        ctl_next[p] = pin_default(strap_speed[p], strap_an_en[p], strap_duplex[p]);
      end else if (sw_busy) begin
        // Writes during soft reset are dropped; reads still answer
        sw_cnt_next[p] = sw_cnt_reg[p] - SCW'(1);
        if (sw_cnt_reg[p] == SCW'(1)) begin
          ctl_next[p] = def_reg[p];
        end
      end else if (wr_ctl[p]) begin
        if (wd[phy_pkg::CTL_RESET]) begin
          ctl_next[p][phy_pkg::CTL_RESET] = 1'b1;
          sw_cnt_next[p] = SW_LOAD;
        end else begin
          // Restart and low bits are not stored, so they read zero
          ctl_next[p] = wd & phy_pkg::CTL_STORE_MASK;
          restart_next[p] = wd[phy_pkg::CTL_AN_RESTART];
          // 1000 Mbps and the reserved code leave the speed unchanged
          if (wd[phy_pkg::CTL_SPD_MSB]) begin
            ctl_next[p][phy_pkg::CTL_SPD_LSB] = ctl_reg[p][phy_pkg::CTL_SPD_LSB];
          end
        end
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        ctl_reg[p]    <= phy_pkg::CTL_RESET_VAL;
        sw_cnt_reg[p] <= '0;
        def_reg[p]    <= phy_pkg::CTL_RESET_VAL;
      end else begin
        ctl_reg[p]    <= ctl_next[p];
        sw_cnt_reg[p] <= sw_cnt_next[p];
        if (!strap_taken_reg) begin
          def_reg[p] <= ctl_next[p];
        end
      end
    end

    // New events win over the clear-on-read
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        rf_reg[p]   <= 1'b0;
        jab_reg[p]  <= 1'b0;
        link_reg[p] <= 1'b0;
      end else begin
        rf_reg[p]   <= remote_fault[p] | (rf_reg[p] & ~rd_stat[p]);
        jab_reg[p]  <= jabber[p] | (jab_reg[p] & ~rd_stat[p]);
        link_reg[p] <= link_up[p] & (link_reg[p] | rd_stat[p]);
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        an_restart[p] <= 1'b0;
        mii_oe[p]     <= 1'b0;
        tx_en_core[p] <= 1'b0;
        tx_er_core[p] <= 1'b0;
      end else begin
        an_restart[p] <= restart_next[p];
        mii_oe[p]     <= ~ctl_next[p][phy_pkg::CTL_ISOLATE];
        tx_en_core[p] <= tx_en_in[p] & ~ctl_reg[p][phy_pkg::CTL_ISOLATE];
        tx_er_core[p] <= tx_er_in[p] & ~ctl_reg[p][phy_pkg::CTL_ISOLATE];
      end
    end

    assign loopback_en[p] = ctl_reg[p][phy_pkg::CTL_LOOP];
    assign speed_100[p]   = ctl_reg[p][phy_pkg::CTL_SPD_LSB];
    assign full_duplex[p] = ctl_reg[p][phy_pkg::CTL_DUPLEX];
    assign an_enable[p]   = ctl_reg[p][phy_pkg::CTL_AN_EN];
    assign power_down[p]  = ctl_reg[p][phy_pkg::CTL_PDOWN];
    assign col_test[p]    = ctl_reg[p][phy_pkg::CTL_COL_TEST];
  end

endmodule : phy_dev
`default_nettype wire

// >>> phy_irq.sv
`default_nettype none
module phy_irq #(
  parameter int W = phy_pkg::IRQ_W
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] set,
  input  wire logic         clr_we,
  input  wire logic [W-1:0] clr_data,
  input  wire logic         mask_we,
  input  wire logic [W-1:0] mask_data,
  output logic      [W-1:0] status,
  output logic      [W-1:0] mask,
  output logic              irq
);
  if (W < 1 || W > 32) begin : g_bad_w
    $error("phy_irq: W must be 1..32");
  end

  wire [W-1:0] clr         = clr_we ? clr_data : '0;
  wire [W-1:0] status_next = set | (status & ~clr);
  wire [W-1:0] mask_next   = mask_we ? mask_data : mask;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= '0;
      mask   <= '0;
      irq    <= 1'b0;
    end else begin
      status <= status_next;
      mask   <= mask_next;
      irq    <= |(status_next & mask_next);
    end
  end
endmodule : phy_irq
`default_nettype wire

// >>> phy_host.sv
`default_nettype none
module phy_host #(
  parameter int REG_WAIT_CYCLES = phy_pkg::REG_WAIT_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  output logic             irq,
  phy_mgmt_if.host         mgmt
);
  if (REG_WAIT_CYCLES < 1) begin : g_bad_wait
    $error("phy_host: REG_WAIT_CYCLES must be positive");
  end

  localparam int WCW = $clog2(REG_WAIT_CYCLES + 1);
  localparam int PCW = $clog2(phy_pkg::PREAMBLE_BITS + 1);
  localparam logic [WCW-1:0] WAIT_LAST = WCW'(REG_WAIT_CYCLES);
  localparam logic [PCW-1:0] PRE_LAST  = PCW'(phy_pkg::PREAMBLE_BITS);
  localparam logic [15:0]    LOW_BITS  = (16'h0001 << phy_pkg::CTL_SPD_MSB) - 16'h0001;

  typedef enum logic [2:0] {PH_BOOT, PH_IDLE, PH_PRE, PH_REQ} phy_hstate_type;
  phy_hstate_type state_reg;

  logic [WCW-1:0]  boot_cnt_reg;
  logic [PCW-1:0]  pre_cnt_reg;
  logic            pend_reg;
  logic [3:0]      a_addr_reg;
  logic            a_write_reg;
  logic [31:0]     cmd_reg;
  logic            swrst_reg;
  logic [15:0]     result_reg;
  logic [phy_pkg::IRQ_W-1:0] ev_reg;
  logic [phy_pkg::IRQ_W-1:0] irq_stat;
  logic [phy_pkg::IRQ_W-1:0] irq_mask;

  wire addr_take = hsel & htrans[1] & hready;
  wire wr_cmd    = pend_reg & a_write_reg & (a_addr_reg == phy_pkg::HR_CMD);
  wire wr_stat   = pend_reg & a_write_reg & (a_addr_reg == phy_pkg::HR_IRQ_STAT);
  wire wr_mask   = pend_reg & a_write_reg & (a_addr_reg == phy_pkg::HR_IRQ_MASK);
  wire start     = wr_cmd & (state_reg == PH_IDLE);
  wire ack_seen  = (state_reg == PH_REQ) & mgmt.ack;
  // Keep polling until the port clears its reset bit
  wire poll_more = swrst_reg & ~mgmt.write & mgmt.rdata[phy_pkg::CTL_RESET];
  wire [31:0] rd_mux =
    (a_addr_reg == phy_pkg::HR_CMD)      ? cmd_reg :
    (a_addr_reg == phy_pkg::HR_RESULT)   ? {14'h0, state_reg != PH_BOOT,
                                            state_reg != PH_IDLE && state_reg != PH_BOOT,
                                            result_reg} :
    (a_addr_reg == phy_pkg::HR_IRQ_STAT) ? 32'(irq_stat) :
    (a_addr_reg == phy_pkg::HR_IRQ_MASK) ? 32'(irq_mask) : 32'h00000000;

  // One wait state per transfer keeps the bus outputs registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_reg    <= 1'b0;
      a_addr_reg  <= 4'h0;
      a_write_reg <= 1'b0;
      hreadyout   <= 1'b1;
      hrdata      <= 32'h00000000;
      hresp       <= 1'b0;
    end else if (pend_reg) begin
      pend_reg  <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= a_write_reg ? 32'h00000000 : rd_mux;
    end else if (addr_take) begin
      pend_reg    <= 1'b1;
      // Addresses past the register window land on an unused offset
      a_addr_reg  <= (haddr[31:4] == 28'h0) ? haddr[3:0] : 4'h1;
      a_write_reg <= hwrite;
      hreadyout   <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg    <= PH_BOOT;
      boot_cnt_reg <= '0;
      pre_cnt_reg  <= '0;
      cmd_reg      <= 32'h00000000;
      swrst_reg    <= 1'b0;
      result_reg   <= 16'h0000;
      ev_reg       <= '0;
      mgmt.req     <= 1'b0;
      mgmt.write   <= 1'b0;
      mgmt.phy     <= 5'h00;
      mgmt.regad   <= 5'h00;
      mgmt.wdata   <= 16'h0000;
    end else begin
      ev_reg <= '0;
      unique case (state_reg)
        PH_BOOT: begin
          // Commands are dropped until the device registers are available
          boot_cnt_reg <= boot_cnt_reg + WCW'(1);
          if (boot_cnt_reg == WAIT_LAST - WCW'(1)) state_reg <= PH_IDLE;
        end
        PH_IDLE: begin
          if (start) begin
            cmd_reg     <= hwdata;
            swrst_reg   <= hwdata[phy_pkg::CMD_SWRST];
            mgmt.phy    <= hwdata[phy_pkg::CMD_PHY_LSB +: 5];
            if (hwdata[phy_pkg::CMD_SWRST]) begin
              mgmt.write <= 1'b1;
              mgmt.regad <= phy_pkg::REG_CTRL;
              mgmt.wdata <= 16'h0000 | (16'h0001 << phy_pkg::CTL_RESET);
            end else begin
              mgmt.write <= hwdata[phy_pkg::CMD_WRITE];
              mgmt.regad <= hwdata[phy_pkg::CMD_REG_LSB +: 5];
              // Unused low control bits always go out as zero
              mgmt.wdata <= hwdata[15:0] & ~LOW_BITS;
            end
            pre_cnt_reg <= '0;
            state_reg   <= PH_PRE;
          end
        end
        PH_PRE: begin
          // Every access carries a full preamble slot
          pre_cnt_reg <= pre_cnt_reg + PCW'(1);
          if (pre_cnt_reg == PRE_LAST - PCW'(1)) begin
            mgmt.req  <= 1'b1;
            state_reg <= PH_REQ;
          end
        end
        PH_REQ: begin
          if (mgmt.ack) begin
            mgmt.req <= 1'b0;
            if (!mgmt.write) result_reg <= mgmt.rdata;
            pre_cnt_reg <= '0;
            if (swrst_reg && (mgmt.write || poll_more)) begin
              mgmt.write <= 1'b0;
              state_reg  <= PH_PRE;
            end else begin
              ev_reg[phy_pkg::IRQ_DONE]     <= 1'b1;
              ev_reg[phy_pkg::IRQ_RST_DONE] <= swrst_reg;
              state_reg <= PH_IDLE;
            end
          end
        end
      endcase
    end
  end

  phy_irq #(.W(phy_pkg::IRQ_W)) u_irq (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .set       (ev_reg),
    .clr_we    (wr_stat),
    .clr_data  (hwdata[phy_pkg::IRQ_W-1:0]),
    .mask_we   (wr_mask),
    .mask_data (hwdata[phy_pkg::IRQ_W-1:0]),
    .status    (irq_stat),
    .mask      (irq_mask),
    .irq       (irq)
  );

  wire unused_ok = ack_seen | hsize[0];
endmodule : phy_host
`default_nettype wire

// >>> phy_link_asserts.sv
`default_nettype none
module phy_link_asserts #(
  parameter int REG_WAIT_CYCLES = phy_pkg::REG_WAIT_CYCLES
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        req,
  input wire logic        write,
  input wire logic [4:0]  phy,
  input wire logic [4:0]  regad,
  input wire logic [15:0] wdata,
  input wire logic        ack,
  input wire logic [15:0] rdata
);
  int         boot_cnt;
  logic [5:0] idle_cnt;
  // Unknown port addresses answer all ones and carry no register content
  wire rd_ok  = ack && !write && rdata != phy_pkg::NO_PHY_DATA;
  wire rd_ctl = rd_ok && regad == phy_pkg::REG_CTRL;
  wire rd_st  = rd_ok && regad == phy_pkg::REG_STAT;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_cnt <= 0;
    end else if (boot_cnt < REG_WAIT_CYCLES) begin
      boot_cnt <= boot_cnt + 1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_cnt <= '0;
    end else if (req) begin
      idle_cnt <= '0;
    end else if (idle_cnt != 6'h3f) begin
      idle_cnt <= idle_cnt + 6'h01;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ack_pulse_a: assert property (ack |=> !ack) else $error("ack wider than one cycle");
  ack_cause_a: assert property (ack |-> $past(req)) else $error("ack without request");
  ack_prompt_a: assert property ($rose(req) |=> ack) else $error("request not answered");
  req_hold_a: assert property (req && !ack |=> req && $stable({write, phy, regad, wdata}))
    else $error("request changed before ack");
  req_drop_a: assert property (ack |=> !req) else $error("request held after ack");
  preamble_gap_a: assert property ($rose(req) |-> idle_cnt >= 6'h1f)
    else $error("request without preamble gap");
  boot_quiet_a: assert property (ack |-> boot_cnt >= REG_WAIT_CYCLES)
    else $error("register answered during boot wait");
  stat_fixed_a: assert property (rd_st |-> (rdata & 16'hffc9) == phy_pkg::STAT_FIXED)
    else $error("status capability bits wrong");
  ctl_auto_a: assert property (rd_ctl |-> !rdata[9] && !rdata[6])
    else $error("control restart or speed msb reads one");
  ctl_low_a: assert property (rd_ctl |-> rdata[5:0] == 6'h00)
    else $error("control low bits not zero");
endmodule : phy_link_asserts
`default_nettype wire

// >>> phy_basic_control_status_regs_tb.sv
`default_nettype none
module phy_basic_control_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          W     = 20;
  localparam logic [4:0]  P0    = 5'h0a;
  localparam logic [4:0]  P1    = 5'h0b;
  localparam logic [4:0]  RC    = phy_pkg::REG_CTRL;
  localparam logic [4:0]  RS    = phy_pkg::REG_STAT;
  localparam logic [31:0] A_CMD = {28'h0, phy_pkg::HR_CMD};
  localparam logic [31:0] A_RES = {28'h0, phy_pkg::HR_RESULT};
  localparam logic [31:0] A_ST  = {28'h0, phy_pkg::HR_IRQ_STAT};
  localparam logic [31:0] A_MSK = {28'h0, phy_pkg::HR_IRQ_MASK};
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  addr_strap;
  logic [1:0]  strap_an_en, strap_speed, strap_duplex, link_up, remote_fault, jabber, an_done;
  logic [1:0]  tx_en_in, tx_er_in, loopback_en, speed_100, full_duplex, an_enable, an_restart;
  logic [1:0]  power_down, col_test, mii_oe, tx_en_core, tx_er_core;
  int          n_errors, num_checks;
  int          n_restart = 0;

  phy_mgmt_if phy_mgmt_if_i ();
  phy_dev #(.PORTS(2), .REG_WAIT_CYCLES(W)) phy_dev_i (.hclk, .hresetn, .mgmt(phy_mgmt_if_i),
    .addr_strap, .strap_an_en, .strap_speed, .strap_duplex, .link_up, .remote_fault, .jabber,
    .an_done, .tx_en_in, .tx_er_in, .loopback_en, .speed_100, .full_duplex, .an_enable,
    .an_restart, .power_down, .col_test, .mii_oe, .tx_en_core, .tx_er_core);
  phy_host #(.REG_WAIT_CYCLES(W)) phy_host_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .irq,
    .mgmt(phy_mgmt_if_i));
  phy_link_asserts #(.REG_WAIT_CYCLES(W)) phy_link_asserts_i (.hclk, .hresetn,
    .req(phy_mgmt_if_i.req), .write(phy_mgmt_if_i.write), .phy(phy_mgmt_if_i.phy),
    .regad(phy_mgmt_if_i.regad), .wdata(phy_mgmt_if_i.wdata), .ack(phy_mgmt_if_i.ack),
    .rdata(phy_mgmt_if_i.rdata));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // The restart strobe lasts one cycle, so it is counted rather than sampled
  always @(posedge hclk) begin
    if (an_restart[0] === 1'b1) n_restart++;
  end

  task wrap_up;
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  task tmo;
    n_errors++;
    wrap_up();
  endtask : tmo

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    k = 0;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 100);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 200);
    r = hrdata;
    if (k >= 200) tmo();
  endtask : ahb

  function automatic logic [31:0] cmd(logic [4:0] p, logic [4:0] r, logic w, logic [15:0] d);
    return {5'h0, w, p, r, d};
  endfunction : cmd

  function automatic logic [31:0] outs();
    return {18'h0, an_enable, speed_100, full_duplex, loopback_en, power_down, col_test, mii_oe};
  endfunction : outs

  task poll(input logic [31:0] a, input int b);
    logic [31:0] r;
    int k;
    k = 0;
    do begin ahb(1'b0, a, 32'h0, r); k++; end while (r[b] !== 1'b1 && k < 300);
    if (k >= 300) tmo();
  endtask : poll

  task mg(input logic [31:0] c, input int b, output logic [15:0] d);
    logic [31:0] r;
    ahb(1'b1, A_CMD, c, r);
    poll(A_ST, b);
    ahb(1'b1, A_ST, 32'h3, r);
    ahb(1'b0, A_RES, 32'h0, r);
    d = r[15:0];
  endtask : mg

  task rd(input logic [4:0] p, input logic [4:0] a, input logic [15:0] e, input string s);
    logic [15:0] d;
    mg(cmd(p, a, 1'b0, 16'h0), phy_pkg::IRQ_DONE, d);
    chk(s, {16'h0, e}, {16'h0, d});
  endtask : rd

  task wr(input logic [4:0] p, input logic [15:0] v);
    logic [15:0] d;
    mg(cmd(p, RC, 1'b1, v), phy_pkg::IRQ_DONE, d);
  endtask : wr

  task t_defaults;
    rd(P0, RC, 16'h1100, "ctl0");
    rd(P1, RC, 16'h2100, "ctl1");
    rd(5'h01, RC, 16'hffff, "nophy");
    chk("outs_reset", {18'h0, 14'b01_10_11_00_00_00_11}, outs());
  endtask : t_defaults

  task t_status;
    rd(P0, RS, 16'h7829, "st_first");
    rd(P0, RS, 16'h782d, "st_live");
    remote_fault <= 2'b01;
    jabber <= 2'b01;
    repeat (3) @(posedge hclk);
    remote_fault <= 2'b00;
    jabber <= 2'b00;
    rd(P0, RS, 16'h783f, "st_latched");
    rd(P0, RS, 16'h782d, "st_cleared");
    link_up <= 2'b00;
    repeat (3) @(posedge hclk);
    link_up <= 2'b01;
    rd(P0, RS, 16'h7829, "link_low");
    rd(P0, RS, 16'h782d, "link_back");
    rd(P1, RS, 16'h7809, "st1");
  endtask : t_status

  task t_control;
    int n0;
    n0 = n_restart;
    wr(P0, 16'h7b80);
    rd(P0, RC, 16'h7980, "ctl_set");
    chk("restart", n0 + 1, n_restart);
    chk("outs_set", {18'h0, 14'b01_11_11_01_01_01_11}, outs());
    wr(P0, 16'h0040);
    rd(P0, RC, 16'h2000, "spd_1000");
    wr(P0, 16'h0000);
    rd(P0, RC, 16'h0000, "spd_10");
    wr(P0, 16'h207f);
    rd(P0, RC, 16'h0000, "spd_rsvd");
    tx_en_in <= 2'b11;
    tx_er_in <= 2'b11;
    wr(P0, 16'h0400);
    rd(P0, RC, 16'h0400, "iso");
    chk("iso_pins", {26'h0, 6'b10_10_10}, {26'h0, mii_oe, tx_en_core, tx_er_core});
    wr(P0, 16'h0000);
    repeat (2) @(posedge hclk);
    chk("live_pins", {26'h0, 6'b11_11_11}, {26'h0, mii_oe, tx_en_core, tx_er_core});
  endtask : t_control

  task t_swreset;
    logic [15:0] d;
    wr(P0, 16'h4000);
    // New pin levels must not reach the register on a soft reset
    strap_an_en <= 2'b10;
    strap_duplex <= 2'b00;
    mg(cmd(P0, RC, 1'b0, 16'h0) | 32'h0800_0000, phy_pkg::IRQ_RST_DONE, d);
    rd(P0, RC, 16'h1100, "swrst_ctl");
    chk("swrst_loop", 32'h0, {30'h0, loopback_en});
  endtask : t_swreset

  task t_irq;
    logic [31:0] r;
    ahb(1'b1, A_MSK, 32'h1, r);
    ahb(1'b1, A_CMD, cmd(P1, RS, 1'b0, 16'h0), r);
    poll(A_ST, phy_pkg::IRQ_DONE);
    repeat (2) @(posedge hclk);
    chk("irq_on", 32'h1, {31'h0, irq});
    ahb(1'b1, A_MSK, 32'h0, r);
    repeat (2) @(posedge hclk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    ahb(1'b1, A_MSK, 32'h1, r);
    repeat (2) @(posedge hclk);
    chk("irq_unmasked", 32'h1, {31'h0, irq});
    ahb(1'b1, A_ST, 32'h1, r);
    repeat (2) @(posedge hclk);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    ahb(1'b0, A_MSK, 32'h0, r);
    chk("mask_reg", 32'h1, r);
    ahb(1'b0, A_RES, 32'h0, r);
    chk("result", 32'h0002_7809, r);
    ahb(1'b1, 32'h10, 32'hffff, r);
    ahb(1'b0, 32'h10, 32'h0, r);
    chk("unmapped", 32'h0, r);
    chk("hresp", 32'h0, {31'h0, hresp});
    ahb(1'b0, A_CMD, 32'h0, r);
    chk("cmd_back", cmd(P1, RS, 1'b0, 16'h0), r);
  endtask : t_irq

  task t_hwreset;
    // A hardware reset takes the strap levels moved during the soft reset
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    poll(A_RES, phy_pkg::RES_READY);
    rd(P0, RC, 16'h0000, "hw_ctl0");
    rd(P1, RC, 16'h3000, "hw_ctl1");
  endtask : t_hwreset

  initial begin
    logic [31:0] r;
    {hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
    {remote_fault, jabber, tx_en_in, tx_er_in} = '0;
    hsize = 3'b010;
    addr_strap = 4'h5;
    strap_an_en = 2'b01;
    strap_speed = 2'b10;
    strap_duplex = 2'b11;
    link_up = 2'b01;
    an_done = 2'b01;
    n_errors = 0;
    num_checks = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Commands written during the boot wait must be dropped
    ahb(1'b1, A_CMD, cmd(P0, RC, 1'b0, 16'h0), r);
    ahb(1'b0, A_CMD, 32'h0, r);
    chk("boot_drop", 32'h0, r);
    poll(A_RES, phy_pkg::RES_READY);
    t_defaults();
    t_status();
    t_control();
    t_swreset();
    t_irq();
    t_hwreset();
    wrap_up();
  end

  initial begin
    repeat (100000) @(posedge hclk);
    tmo();
  end
endmodule : phy_basic_control_status_regs_tb
`default_nettype wire
